// ### hw/tx_rate_limit_pkg.sv
// Constants, register map and state codes for the transmit rate limiter
package tx_rate_limit_pkg;
   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_HDR_SIZE = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_GAP_COMP = 8'h08;
   localparam logic [7:0] OFS_RATIO = 8'h0C;
   localparam logic [7:0] OFS_FR_START = 8'h10;
   localparam logic [7:0] OFS_OVF_FLAG = 8'h14;
   localparam logic [7:0] OFS_UNF_FLAG = 8'h18;
   localparam logic [7:0] OFS_GAP_FLAG = 8'h1C;
   // Mode register field positions
   localparam int MODE_OH_BIT = 0;
   localparam int MODE_PR_BIT = 1;
   localparam int MODE_FR_BIT = 2;
   localparam int MODE_ACC_BIT = 3;
   localparam int MODE_PRE_BIT = 4;
   localparam int MODE_HDR_BIT = 5;
   localparam int MODE_SCALE_LSB = 8;
   localparam int MODE_SCALE_W = 4;
   localparam int MODE_W = 12;
   // Field widths
   localparam int HDR_W = 16;
   localparam int COMP_W = 8;
   localparam int RATIO_W = 19;
   localparam int FR_W = 16;
   // Reset values
   localparam logic [HDR_W-1:0] HDR_RST = 16'h0000;
   localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
   localparam logic [COMP_W-1:0] COMP_RST = 8'h0C;
   localparam logic [RATIO_W-1:0] RATIO_RST = 19'h00480;
   localparam logic [FR_W-1:0] FR_RST = 16'h0000;
   // Standard gap and frame-spacing threshold, in bytes
   localparam logic [7:0] IPG_STD_BYTES = 8'h0C;
   localparam logic [7:0] FR_MIN_EXT = 8'h0C;
   // Fixed 256 factor of the payload rate formula, as a shift
   localparam int RATIO_SHIFT = 8;
   // Largest legal scale exponent
   localparam int SCALE_MAX = 10;
   // Controller states
   typedef enum logic [1:0] {
      ST_PASS = 2'b01,
      ST_CALC = 2'b10
   } rl_state_e;
endpackage

// ### hw/gap_divider.sv
// Serial restoring divider for the payload rate gap and its carried fraction
`timescale 1ns/1ps
module gap_divider #(
   parameter int NUM_W = 34,
   parameter int DEN_W = 19
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [NUM_W-1:0] numer,
   input wire logic [DEN_W-1:0] denom,
   output logic done,
   output logic [NUM_W-1:0] quot,
   output logic [DEN_W-1:0] rem
);
   localparam int CNT_W = $clog2(NUM_W + 1);
   localparam logic [CNT_W-1:0] ITER = CNT_W'(NUM_W);
   logic [NUM_W-1:0] shift_reg; // Numerator bits out, quotient bits in
   logic [DEN_W-1:0] rem_reg; // Partial remainder, below denom whenever denom is nonzero
   logic [DEN_W-1:0] den_reg; // Divisor held for the whole run
   logic [CNT_W-1:0] cnt_reg; // Steps still to go
   logic done_reg;
   wire [DEN_W:0] trial = {rem_reg, shift_reg[NUM_W-1]};
   wire fits = trial >= {1'b0, den_reg};
   wire [DEN_W:0] diff = trial - {1'b0, den_reg};
   // One quotient bit per clock; a run takes NUM_W clocks
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shift_reg <= '0;
         rem_reg <= '0;
         den_reg <= '0;
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end
      else if (start)
      begin
         shift_reg <= numer;
         rem_reg <= '0;
         den_reg <= denom;
         cnt_reg <= ITER;
         done_reg <= 1'b0;
      end
      else if (cnt_reg != '0)
      begin
         shift_reg <= {shift_reg[NUM_W-2:0], fits};
         rem_reg <= fits ? diff[DEN_W-1:0] : trial[DEN_W-1:0];
         cnt_reg <= cnt_reg - 1'b1;
         done_reg <= (cnt_reg == 1);
      end
      else
         done_reg <= 1'b0;
   end
   assign done = done_reg;
   assign quot = shift_reg;
   assign rem = rem_reg;
endmodule

// ### hw/tx_ipg_rate_limiter.sv
// Transmit gap rate limiter: frame overhead, payload rate and frame rate modes
//
// Overview of operation
// - Several modes enabled: use largest extra gap
// - Overhead plus payload only, accumulate: sum gaps
// - Payload bit zero: preamble never counted
// - Payload bit one: skip leading header bytes
// - One header size shared by all ports
// - Payload options only affect payload, frame rate
// - Overhead and payload extra gaps scaled by two to the exponent
// - Overhead mode raises gap to compensation value
// - Payload gap is 2^S times 256/R times L
// - Total gap is twelve plus extra gap
// - Fraction of payload gap carried to next frame
// - Spacing counter loads at start of payload
// - Spacing counter drops one per payload byte
// - Frame end adds counter value above twelve
// - Sticky flag on cell buffer overflow
// - Sticky flag on cell buffer underrun
// - Sticky flag when any mode stretches gap
// - Separate enable for each of three modes
// - Preamble select bit decides preamble counting with payload bit one
`timescale 1ns/1ps
module tx_ipg_rate_limiter
   import tx_rate_limit_pkg::*;
#(
   parameter int LEN_W = 16,
   parameter int EXT_W = 24
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [tx_rate_limit_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tx_rate_limit_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [tx_rate_limit_pkg::DATA_W-1:0] reg_rdata,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_pre,
   input wire logic in_last,
   output logic in_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_pre,
   output logic out_last,
   output logic gap_valid,
   output logic [EXT_W:0] gap_bytes,
   input wire logic buf_overflow_evt,
   input wire logic buf_underrun_evt
);
   import tx_rate_limit_pkg::*;
   localparam int NUM_W = LEN_W + RATIO_SHIFT + SCALE_MAX;

   // Shifts a value left by the scale exponent, kept at width
   function automatic logic [NUM_W-1:0] scale_up(input logic [NUM_W-1:0] v,
                                                 input logic [MODE_SCALE_W-1:0] s);
      scale_up = v << s;
   endfunction

   // Larger of two gap values
   function automatic logic [EXT_W:0] max2(input logic [EXT_W:0] a, input logic [EXT_W:0] b);
      max2 = (a > b) ? a : b;
   endfunction

   // Configuration and flag registers
   logic [HDR_W-1:0] hdr_size_reg; // Single header size for all ports
   logic [MODE_W-1:0] mode_reg;
   logic [COMP_W-1:0] comp_reg;
   logic [RATIO_W-1:0] ratio_reg;
   logic [FR_W-1:0] fr_start_reg;
   logic ovf_flag_reg;
   logic unf_flag_reg;
   logic gap_flag_reg;
   logic [DATA_W-1:0] rdata_reg;
   // Datapath state
   rl_state_e state_reg;
   logic ready_reg;
   logic out_valid_reg;
   logic [7:0] out_data_reg;
   logic out_pre_reg;
   logic out_last_reg;
   logic gap_valid_reg;
   logic [EXT_W:0] gap_bytes_reg;
   logic [LEN_W-1:0] pos_reg; // Non-preamble bytes seen in this frame
   logic [LEN_W-1:0] len_reg; // Counted payload bytes in this frame
   logic [FR_W-1:0] fr_cnt_reg; // Frame spacing counter
   logic fr_run_reg; // Payload has begun, counter loaded
   logic [RATIO_W-1:0] frac_reg; // Carried remainder of the payload gap
   logic div_start_reg;
   logic div_done;
   logic [NUM_W-1:0] div_quot;
   logic [RATIO_W-1:0] div_rem;

   // Mode field decode, one enable per mode
   wire oh_en = mode_reg[MODE_OH_BIT];
   wire pr_en = mode_reg[MODE_PR_BIT];
   wire fr_en = mode_reg[MODE_FR_BIT];
   wire acc_en = mode_reg[MODE_ACC_BIT];
   wire pre_sel = mode_reg[MODE_PRE_BIT];
   wire hdr_sub = mode_reg[MODE_HDR_BIT];
   wire [MODE_SCALE_W-1:0] scale = mode_reg[MODE_SCALE_LSB +: MODE_SCALE_W];

   // Register decode
   wire wr_hdr = reg_wr && reg_addr == OFS_HDR_SIZE;
   wire wr_mode = reg_wr && reg_addr == OFS_MODE;
   wire wr_comp = reg_wr && reg_addr == OFS_GAP_COMP;
   wire wr_ratio = reg_wr && reg_addr == OFS_RATIO;
   wire wr_fr = reg_wr && reg_addr == OFS_FR_START;
   wire clr_ovf = reg_wr && reg_addr == OFS_OVF_FLAG && reg_wdata[0];
   wire clr_unf = reg_wr && reg_addr == OFS_UNF_FLAG && reg_wdata[0];
   wire clr_gap = reg_wr && reg_addr == OFS_GAP_FLAG && reg_wdata[0];

   // Byte accounting; these options touch only payload and frame rate
   wire acc = in_valid && ready_reg;
   wire in_hdr = hdr_sub && (pos_reg < LEN_W'(hdr_size_reg));
   // Preamble counts only with header mode on and the select bit set
   wire counted = in_pre ? (hdr_sub && pre_sel) : !in_hdr;
   wire cnt_byte = acc && counted;
   wire [LEN_W-1:0] len_next = len_reg + LEN_W'(cnt_byte);
   // Load on first payload byte, then one down per byte
   wire [FR_W-1:0] fr_base = fr_run_reg ? fr_cnt_reg : fr_start_reg;
   wire [FR_W-1:0] fr_dec = (fr_base != '0) ? fr_base - 1'b1 : fr_base;
   wire [FR_W-1:0] fr_cnt_next = cnt_byte ? fr_dec : fr_cnt_reg;
   wire frame_end = acc && in_last;
   // Numerator of L * 2^S * 256 plus the leftover fraction
   wire [NUM_W-1:0] numer = scale_up(NUM_W'(len_next) << RATIO_SHIFT, scale)
                            + NUM_W'(frac_reg);

   // Per-mode extra gaps
   wire [NUM_W-1:0] oh_raw = scale_up(NUM_W'(comp_reg - COMP_W'(IPG_STD_BYTES)), scale);
   wire [EXT_W:0] ext_oh = (oh_en && comp_reg > COMP_W'(IPG_STD_BYTES))
                           ? (EXT_W+1)'(oh_raw) : '0;
   wire [EXT_W:0] ext_pr = pr_en ? (EXT_W+1)'(div_quot) : '0;
   wire [EXT_W:0] ext_fr = (fr_en && fr_cnt_reg > FR_W'(FR_MIN_EXT))
                           ? (EXT_W+1)'(fr_cnt_reg) : '0;
   wire sum_sel = acc_en && oh_en && pr_en && !fr_en;
   wire [EXT_W:0] ext_sum = ext_oh + ext_pr;
   wire [EXT_W:0] ext_max = max2(max2(ext_oh, ext_pr), ext_fr);
   wire [EXT_W:0] ext_gap = sum_sel ? ext_sum : ext_max;
   wire [EXT_W:0] total_gap = ext_gap + (EXT_W+1)'(IPG_STD_BYTES);
   wire calc_done = state_reg == ST_CALC && div_done;

   // Read mux; unmapped offsets read zero
   logic [DATA_W-1:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      unique case (reg_addr)
         OFS_HDR_SIZE: rd_mux = DATA_W'(hdr_size_reg);
         OFS_MODE: rd_mux = DATA_W'(mode_reg);
         OFS_GAP_COMP: rd_mux = DATA_W'(comp_reg);
         OFS_RATIO: rd_mux = DATA_W'(ratio_reg);
         OFS_FR_START: rd_mux = DATA_W'(fr_start_reg);
         OFS_OVF_FLAG: rd_mux = DATA_W'(ovf_flag_reg);
         OFS_UNF_FLAG: rd_mux = DATA_W'(unf_flag_reg);
         OFS_GAP_FLAG: rd_mux = DATA_W'(gap_flag_reg);
         default: rd_mux = '0;
      endcase
   end

   // Configuration writes; range limits are left to software
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hdr_size_reg <= HDR_RST;
         mode_reg <= MODE_RST;
         comp_reg <= COMP_RST;
         ratio_reg <= RATIO_RST;
         fr_start_reg <= FR_RST;
         rdata_reg <= '0;
      end
      else
      begin
         if (wr_hdr) hdr_size_reg <= reg_wdata[HDR_W-1:0];
         if (wr_mode) mode_reg <= reg_wdata[MODE_W-1:0];
         if (wr_comp) comp_reg <= reg_wdata[COMP_W-1:0];
         if (wr_ratio) ratio_reg <= reg_wdata[RATIO_W-1:0];
         if (wr_fr) fr_start_reg <= reg_wdata[FR_W-1:0];
         // Read data valid only in the cycle after the strobe
         rdata_reg <= reg_rd ? rd_mux : '0;
      end
   end

   // Sticky flags; a same-cycle event beats the clear
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ovf_flag_reg <= 1'b0;
         unf_flag_reg <= 1'b0;
         gap_flag_reg <= 1'b0;
      end
      else
      begin
         ovf_flag_reg <= buf_overflow_evt || (ovf_flag_reg && !clr_ovf);
         unf_flag_reg <= buf_underrun_evt || (unf_flag_reg && !clr_unf);
         gap_flag_reg <= (calc_done && ext_gap != '0)
                         || (gap_flag_reg && !clr_gap);
      end
   end

   // Frame byte counters; all but the spacing counter cleared at frame end for the next frame
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pos_reg <= '0;
         len_reg <= '0;
         fr_run_reg <= 1'b0;
         fr_cnt_reg <= '0;
      end
      else if (frame_end)
      begin
         pos_reg <= '0;
         len_reg <= '0;
         fr_run_reg <= 1'b0;
         fr_cnt_reg <= fr_cnt_next; // Held for the gap decision
      end
      else if (acc)
      begin
         if (!in_pre) pos_reg <= pos_reg + 1'b1;
         len_reg <= len_next;
         if (cnt_byte) fr_run_reg <= 1'b1;
         fr_cnt_reg <= fr_cnt_next;
      end
   end

   // Controller: stall intake while the gap is worked out
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= ST_PASS;
         ready_reg <= 1'b1;
         div_start_reg <= 1'b0;
         frac_reg <= '0;
         gap_valid_reg <= 1'b0;
         gap_bytes_reg <= '0;
      end
      else
      begin
         div_start_reg <= 1'b0;
         gap_valid_reg <= 1'b0;
         unique case (state_reg)
            ST_PASS:
            begin
               if (frame_end)
               begin
                  ready_reg <= 1'b0;
                  div_start_reg <= 1'b1;
                  state_reg <= ST_CALC;
               end
            end
            ST_CALC:
            begin
               if (div_done)
               begin
                  frac_reg <= pr_en ? div_rem : '0;
                  gap_bytes_reg <= total_gap;
                  gap_valid_reg <= 1'b1;
                  ready_reg <= 1'b1;
                  state_reg <= ST_PASS;
               end
            end
            default:
            begin
               ready_reg <= 1'b1;
               state_reg <= ST_PASS;
            end
         endcase
      end
   end

   // Registered byte stream towards the port MAC
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
         out_pre_reg <= 1'b0;
         out_last_reg <= 1'b0;
      end
      else
      begin
         out_valid_reg <= acc;
         out_data_reg <= in_data;
         out_pre_reg <= in_pre;
         out_last_reg <= frame_end;
      end
   end

   // Numerator register is captured at the same edge as the start pulse
   logic [NUM_W-1:0] numer_reg;
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n) numer_reg <= '0;
      else if (frame_end) numer_reg <= numer;
   end

   gap_divider #(.NUM_W(NUM_W), .DEN_W(RATIO_W)) u_div (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .start(div_start_reg),
      .numer(numer_reg),
      .denom(ratio_reg),
      .done(div_done),
      .quot(div_quot),
      .rem(div_rem)
   );

   assign in_ready = ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;
   assign out_pre = out_pre_reg;
   assign out_last = out_last_reg;
   assign gap_valid = gap_valid_reg;
   assign gap_bytes = gap_bytes_reg;
   assign reg_rdata = rdata_reg;

   // Checks on the gap decision and the flags
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   sequence s_frame_end;
      frame_end;
   endsequence
   sequence s_gap_out;
      ##[2:40] gap_valid;
   endsequence

   a_gap_after_end: assert property (s_frame_end |-> s_gap_out)
      else $error("no gap report after frame end");
   a_stall_to_gap: assert property (s_frame_end |=> !in_ready until gap_valid)
      else $error("intake not stalled during gap calculation");
   a_gap_floor: assert property (gap_valid |-> gap_bytes >= (EXT_W+1)'(IPG_STD_BYTES))
      else $error("gap below standard");
   a_sum_mode: assert property (calc_done && sum_sel |=> gap_bytes ==
      $past(ext_oh) + $past(ext_pr) + (EXT_W+1)'(IPG_STD_BYTES))
      else $error("accumulated gap is not the sum");
   a_max_mode: assert property (calc_done && !sum_sel |=> gap_bytes >=
      $past(ext_fr) + (EXT_W+1)'(IPG_STD_BYTES))
      else $error("gap below frame rate extension");
   a_stretch_flag: assert property (calc_done && ext_gap != '0 |=> gap_flag_reg [*2])
      else $error("stretch flag not held");
   a_ovf_wins: assert property (buf_overflow_evt |=> ovf_flag_reg)
      else $error("overflow event lost");
   a_unf_wins: assert property (buf_underrun_evt |=> unf_flag_reg)
      else $error("underrun event lost");
   a_fr_load: assert property (cnt_byte && !fr_run_reg && fr_start_reg != '0 && !frame_end
      |=> fr_cnt_reg == $past(fr_start_reg) - 1'b1)
      else $error("spacing counter not loaded");
   a_fr_step: assert property (cnt_byte && fr_run_reg && fr_cnt_reg != '0
      |=> fr_cnt_reg == $past(fr_cnt_reg) - 1'b1)
      else $error("spacing counter not stepped");
endmodule

// ### tb/queue_mac_model.sv
// Queue-side byte source and MAC-side byte sink around the rate limiter
`timescale 1ns/1ps
module queue_mac_model (
   input wire logic core_clk,
   input wire logic in_ready,
   input wire logic out_valid,
   output logic in_valid,
   output logic [7:0] in_data,
   output logic in_pre,
   output logic in_last,
   input wire logic [7:0] out_data,
   input wire logic out_pre,
   input wire logic out_last,
   output logic hang,
   output int out_cnt,
   output logic [31:0] out_sig
);
   // Idle source, empty sink at time zero
   initial
   begin
      in_valid = 1'b0;
      in_data = 8'hA5;
      in_pre = 1'b0;
      in_last = 1'b0;
      hang = 1'b0;
      out_cnt = 0;
      out_sig = '0;
   end
   // MAC side never stalls; counts bytes and folds data and marks into a signature
   // Unknown data or marks turn the signature unknown, so they cannot slip past
   always @(posedge core_clk)
      if (out_valid === 1'b1)
      begin
         out_cnt <= out_cnt + 1;
         out_sig <= out_sig + 32'(out_data) + (out_pre ? 32'h100 : 32'h0)
                    + (out_last ? 32'h200 : 32'h0);
      end
   // Offer one frame, preamble first; each byte held until taken
   task automatic send(input int npre, input int ndat, input bit slow);
      int k;
      int w;
      for (k = 0; k < npre + ndat; k++)
      begin
         in_valid <= 1'b1;
         in_data <= (k < npre) ? 8'h55 : k[7:0];
         in_pre <= (k < npre);
         in_last <= (k == npre + ndat - 1);
         w = 0;
         do
         begin
            @(posedge core_clk);
            w++;
         end
         while (in_ready !== 1'b1 && w < 100);
         // Back-pressure that never lifts is a hang
         if (w >= 100)
            hang <= 1'b1;
         if (slow || k == npre + ndat - 1)
         begin
            // Released bus shows inverted data so stale bytes cannot pass
            in_valid <= 1'b0;
            in_data <= ~in_data;
            in_pre <= 1'b0;
            in_last <= 1'b0;
            if (k != npre + ndat - 1)
               @(posedge core_clk);
         end
      end
   endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the transmit gap rate limiter
`timescale 1ns/1ps
module tb;
   import tx_rate_limit_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic in_valid, in_pre, in_last, in_ready, out_valid, out_pre, out_last, gap_valid;
   logic [7:0] in_data, out_data;
   logic [24:0] gap_bytes;
   logic [1:0] evt = 2'b00; // Overflow in bit 0, underrun in bit 1
   logic hang;
   int out_cnt;
   logic [31:0] out_sig; // Sink signature of data, preamble and last marks
   logic [31:0] sig_exp = '0; // Signature the sink should have built
   int err_total = 0;
   int n_checks = 0;
   int sent = 0; // Bytes offered so far, for the sink count
   logic [DATA_W-1:0] rv;

   // 10 MHz clock
   always #50 core_clk = ~core_clk;

   tx_ipg_rate_limiter dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .in_valid(in_valid), .in_data(in_data), .in_pre(in_pre), .in_last(in_last),
      .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_pre(out_pre),
      .out_last(out_last), .gap_valid(gap_valid), .gap_bytes(gap_bytes),
      .buf_overflow_evt(evt[0]), .buf_underrun_evt(evt[1]));

   queue_mac_model src (.core_clk(core_clk), .in_ready(in_ready), .out_valid(out_valid),
      .in_valid(in_valid), .in_data(in_data), .in_pre(in_pre), .in_last(in_last),
      .out_data(out_data), .out_pre(out_pre), .out_last(out_last),
      .hang(hang), .out_cnt(out_cnt), .out_sig(out_sig));

   // Verdict and end of run; also reached when a wait runs out
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One compare for every result, registers and gaps alike
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // Bus write; a spare cycle keeps strobes from being driven twice at one edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   // Bus read; data stands only in the cycle after the strobe
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      rv = reg_rdata;
      chk32(nm, e, rv);
   endtask
   // One frame, then the gap reported to the MAC
   task automatic frame(input int np, input int nd, input bit slow, input int e);
      int w;
      src.send(np, nd, slow);
      sent += np + nd;
      // Preamble bytes are 55 with the preamble mark, data bytes carry their index
      sig_exp += 32'h200 + 32'(np) * 32'h155;
      for (int k = np; k < np + nd; k++)
         sig_exp += 32'(k[7:0]);
      w = 0;
      do
      begin
         @(posedge core_clk);
         w++;
      end
      while (gap_valid !== 1'b1 && w < 80);
      if (w >= 80 || hang)
      begin
         err_total++;
         wrap_up();
      end
      chk32("gap_bytes", e, 32'(gap_bytes));
      chk32("bytes_out", sent, out_cnt);
      chk32("out_sig", sig_exp, out_sig);
   endtask

   // Reset values, unmapped place, field width
   task automatic regs_reset;
      logic [31:0] exp [8] = '{32'h0, 32'h0, 32'h0C, 32'h480, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 8; i++)
         rdchk("reset_value", 8'(4 * i), exp[i]);
      rdchk("unmapped", 8'h20, 32'h0);
      // Upper bits dropped; the kept field stays inside the legal ratio range
      wr(OFS_RATIO, 32'hFFF7E7FF);
      rdchk("ratio_width", OFS_RATIO, 32'h0007E7FF);
   endtask
   // Overhead mode and the stretched-gap flag
   task automatic overhead_case;
      frame(0, 10, 1'b0, 12);
      rdchk("no_stretch", OFS_GAP_FLAG, 32'h0);
      wr(OFS_GAP_COMP, 32'h14);
      wr(OFS_MODE, 32'h001);
      frame(0, 10, 1'b0, 20);
      rdchk("stretch", OFS_GAP_FLAG, 32'h1);
      wr(OFS_GAP_FLAG, 32'h1);
      rdchk("stretch_clr", OFS_GAP_FLAG, 32'h0);
      wr(OFS_MODE, 32'h131);
      frame(2, 10, 1'b1, 28);
   endtask
   // Payload rate with carried fraction, scaling, header and preamble
   task automatic payload_case;
      wr(OFS_RATIO, 32'h500);
      wr(OFS_MODE, 32'h002);
      frame(0, 10, 1'b0, 14);
      wr(OFS_RATIO, 32'h600);
      frame(0, 10, 1'b0, 13);
      frame(0, 10, 1'b0, 14);
      wr(OFS_MODE, 32'h202);
      frame(0, 3, 1'b0, 14);
      wr(OFS_HDR_SIZE, 32'h4);
      wr(OFS_MODE, 32'h222);
      frame(0, 10, 1'b0, 16);
      wr(OFS_MODE, 32'h212);
      frame(2, 3, 1'b0, 14);
   endtask
   // Frame spacing counter, threshold of twelve, preamble counting
   task automatic rate_case;
      wr(OFS_FR_START, 32'h1E);
      wr(OFS_MODE, 32'h004);
      frame(0, 10, 1'b0, 32);
      wr(OFS_FR_START, 32'h16);
      frame(0, 10, 1'b0, 12);
      wr(OFS_FR_START, 32'h17);
      frame(0, 10, 1'b1, 25);
      wr(OFS_FR_START, 32'h1E);
      wr(OFS_MODE, 32'h034);
      frame(2, 10, 1'b0, 34);
      wr(OFS_MODE, 32'h024);
      frame(2, 10, 1'b0, 36);
   endtask
   // Largest gap wins unless accumulation of two modes is asked for
   task automatic combo_case;
      wr(OFS_RATIO, 32'h500);
      wr(OFS_MODE, 32'h003);
      frame(0, 10, 1'b0, 20);
      wr(OFS_MODE, 32'h00B);
      frame(0, 10, 1'b0, 22);
      wr(OFS_MODE, 32'h00F);
      frame(0, 10, 1'b0, 32);
   endtask
   // Buffer flag: set, survives a zero write, event beats a clear
   task automatic flag_case(input bit unf);
      logic [7:0] a;
      a = unf ? OFS_UNF_FLAG : OFS_OVF_FLAG;
      evt[unf] <= 1'b1;
      @(posedge core_clk);
      evt[unf] <= 1'b0;
      @(posedge core_clk);
      rdchk("flag_set", a, 32'h1);
      wr(a, 32'h0);
      rdchk("flag_w0", a, 32'h1);
      // Event and clear meet at one edge only, so the clear cannot hide behind a late event
      evt[unf] <= 1'b1;
      reg_addr <= a;
      reg_wdata <= 32'h1;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      evt[unf] <= 1'b0;
      reg_wr <= 1'b0;
      @(posedge core_clk);
      rdchk("flag_race", a, 32'h1);
      wr(a, 32'h1);
      rdchk("flag_clr", a, 32'h0);
   endtask

   // Main sequence: 12 cycles of reset, then every scenario
   initial
   begin
      repeat (12) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      regs_reset();
      overhead_case();
      payload_case();
      rate_case();
      combo_case();
      flag_case(1'b0);
      flag_case(1'b1);
      wrap_up();
   end
endmodule
